// *** spc_pkg.sv ***
// spc_pkg: register map, field layout and packet layout of the packet controller
// assumes: one 32-bit word per register, byte addresses on an 8-bit apb address
package spc_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_STATUS_CONFIG       = 8'h00;
  localparam logic [7:0] OFS_UNUSED_SLOT         = 8'h04;
  localparam logic [7:0] OFS_OUTGOING_PAYLOAD    = 8'h08;
  localparam logic [7:0] OFS_OUTGOING_KEY_DEST   = 8'h0C;
  localparam logic [7:0] OFS_INCOMING_PAYLOAD    = 8'h10;
  localparam logic [7:0] OFS_INCOMING_KEY_SOURCE = 8'h14;

  // ==========================================================================
  // status_config fields
  localparam int CFG_SRC_LSB   = 0;
  localparam int CFG_SRC_W     = 16;
  localparam int CFG_RXCTL_LSB = 16;
  localparam int CFG_TYPE_MC   = 25;
  localparam int CFG_TX_FULL   = 26;
  localparam int CFG_SPARE     = 27;
  localparam int CFG_PERR      = 28;
  localparam int CFG_RCVD      = 29;
  localparam int CFG_IEN       = 30;
  localparam int CFG_IST       = 31;

  localparam logic [15:0] SRC_ID_RESET = 16'h0000;

  // ==========================================================================
  // outgoing_key_dest layout for point-to-point sends
  localparam int KD_DEST_LSB = 0;
  localparam int KD_SEQ_LSB  = 16;

  // ==========================================================================
  // packet header: 40 bits, control byte in the low 8
  localparam int HDR_W        = 40;
  localparam int WORD_W       = 32;
  localparam int HDR_KEY_LSB  = 8;
  localparam int HDR_SRC_LSB  = 8;
  localparam int HDR_DEST_LSB = 24;
  localparam int ID_W         = 16;

  localparam int CB_PARITY    = 0;
  localparam int CB_SPARE     = 1;
  localparam int CB_STAMP_LSB = 2;
  localparam int CB_SEQ_LSB   = 4;
  localparam int CB_DATA      = 6;
  localparam int CB_TYPE      = 7;

  localparam logic       TYPE_MULTICAST = 1'b0;
  localparam logic       TYPE_P2P       = 1'b1;
  localparam logic [1:0] EMERG_NORMAL   = 2'h0;
  localparam logic [1:0] EMERG_COMBINED = 2'h1;
  localparam logic [1:0] EMERG_ONLY     = 2'h2;
  localparam logic [1:0] EMERG_REVERT   = 2'h3;

endpackage : spc_pkg

// *** spc_comm_ctrl.sv ***
// spc_comm_ctrl: per-processor packet controller, apb registers to packet network
// assumes: network ports synchronous to pclk; one send slot and one receive slot
//
// What this block does
// - two 40-bit kinds, multicast key, point-to-point address
// - optional 32-bit payload after either header
// - multicast header is key then control byte
// - point-to-point header: destination, source, control
// - bit 0 makes whole packet odd parity
// - bit 1 copies spare setting; shown on receive
// - bits 3:2 carry gray time phase at launch
// - point-to-point bits 5:4 give sequence position
// - multicast bits 5:4 hold emergency routing state, always sent as normal
// - bit 6 flags attached payload word
// - bit 7 gives kind, 1 point-to-point
// - offset 0x0 status and configuration register
// - offset 0x8 write-only outgoing payload
// - offset 0xC write-only key or destination
// - 0x14 incoming key/source, 0x10 incoming payload
// - key/destination write launches one packet
// - payload only if written since last launch
// - config bit 25 picks multicast or point-to-point
// - incoming key read-sensitive; payload valid until key read
`timescale 1ns/1ps
module spc_comm_ctrl
  import spc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        time_phase,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic      [HDR_W-1:0]  tx_header,
  output logic      [WORD_W-1:0] tx_payload,
  input  wire logic              rx_valid,
  output logic                   rx_ready,
  input  wire logic [HDR_W-1:0]  rx_header,
  input  wire logic [WORD_W-1:0] rx_payload
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic              rd_clear;
    logic [ID_W-1:0]   src_id;
    logic              type_mc;
    logic              spare;
    logic              ien;
    logic [WORD_W-1:0] out_word;
    logic              out_pending;
    logic              tx_valid;
    logic [HDR_W-1:0]  tx_header;
    logic [WORD_W-1:0] tx_payload;
    logic              rx_ready;
    logic              rcvd;
    logic              perr;
    logic [7:0]        rx_ctl;
    logic [WORD_W-1:0] rx_key;
    logic [WORD_W-1:0] rx_word;
  } spc_state_s;

  spc_state_s st_reg;
  spc_state_s st_next;

  // odd count of ones over header and, when flagged, the payload
  function automatic logic odd_ones(input logic [HDR_W-1:0] hdr, input logic [WORD_W-1:0] word);
    logic [WORD_W-1:0] w;
    w = hdr[CB_DATA] ? word : '0;
    return (^hdr) ^ (^w);
  endfunction

  // ==========================================================================
  // next state
  logic              setup;
  logic              access;
  logic              arrive;
  logic [HDR_W-1:0]  hdr;
  logic [31:0]       status_word;

  always_comb begin
    st_next = st_reg;
    setup   = psel & ~penable;
    access  = psel & penable & st_reg.pready;
    arrive  = rx_valid & st_reg.rx_ready;
    hdr     = '0;
    status_word = '0;
    status_word[CFG_SRC_LSB +: CFG_SRC_W] = st_reg.src_id;
    status_word[CFG_RXCTL_LSB +: 8]       = st_reg.rx_ctl;
    status_word[CFG_TYPE_MC]              = st_reg.type_mc;
    status_word[CFG_TX_FULL]              = st_reg.tx_valid;
    status_word[CFG_SPARE]                = st_reg.spare;
    status_word[CFG_PERR]                 = st_reg.perr;
    status_word[CFG_RCVD]                 = st_reg.rcvd;
    status_word[CFG_IEN]                  = st_reg.ien;
    status_word[CFG_IST]                  = st_reg.ien & st_reg.rcvd;

    // no wait state: answer prepared in setup, given in the first access cycle
    st_next.pready   = 1'b0;
    st_next.pslverr  = 1'b0;
    if (setup) begin
      st_next.pready   = 1'b1;
      st_next.prdata   = '0;
      st_next.rd_clear = 1'b0;
      if (pwrite) begin
        unique case (paddr)
          OFS_STATUS_CONFIG, OFS_OUTGOING_PAYLOAD: st_next.pslverr = 1'b0;
          // send slot busy: refuse rather than overwrite a packet in flight
          OFS_OUTGOING_KEY_DEST: st_next.pslverr = st_reg.tx_valid;
          default: st_next.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          OFS_STATUS_CONFIG:       st_next.prdata = status_word;
          OFS_INCOMING_PAYLOAD:    st_next.prdata = st_reg.rx_word;
          OFS_INCOMING_KEY_SOURCE: begin
            st_next.prdata   = st_reg.rx_key;
            // only a read that saw a packet frees the slot
            st_next.rd_clear = st_reg.rcvd;
          end
          default: st_next.pslverr = 1'b1;
        endcase
      end
    end

    // send side
    if (st_reg.tx_valid & tx_ready) begin
      st_next.tx_valid = 1'b0;
    end
    if (access & pwrite & ~st_reg.pslverr) begin
      unique case (paddr)
        OFS_STATUS_CONFIG: begin
          st_next.src_id  = pwdata[CFG_SRC_LSB +: CFG_SRC_W];
          st_next.type_mc = pwdata[CFG_TYPE_MC];
          st_next.spare   = pwdata[CFG_SPARE];
          st_next.ien     = pwdata[CFG_IEN];
        end
        OFS_OUTGOING_PAYLOAD: begin
          st_next.out_word    = pwdata;
          st_next.out_pending = 1'b1;
        end
        OFS_OUTGOING_KEY_DEST: begin
          if (st_reg.type_mc) begin
            hdr[HDR_KEY_LSB +: WORD_W] = pwdata;
            hdr[CB_SEQ_LSB +: 2]       = EMERG_NORMAL;
            hdr[CB_TYPE]               = TYPE_MULTICAST;
          end else begin
            hdr[HDR_DEST_LSB +: ID_W]  = pwdata[KD_DEST_LSB +: ID_W];
            hdr[HDR_SRC_LSB +: ID_W]   = st_reg.src_id;
            hdr[CB_SEQ_LSB +: 2]       = pwdata[KD_SEQ_LSB +: 2];
            hdr[CB_TYPE]               = TYPE_P2P;
          end
          hdr[CB_SPARE]            = st_reg.spare;
          hdr[CB_STAMP_LSB +: 2]   = time_phase;
          hdr[CB_DATA]             = st_reg.out_pending;
          hdr[CB_PARITY]           = ~odd_ones(hdr, st_reg.out_word);
          st_next.tx_header   = hdr;
          st_next.tx_payload  = st_reg.out_pending ? st_reg.out_word : '0;
          st_next.tx_valid    = 1'b1;
          st_next.out_pending = 1'b0;
        end
        default: st_next.out_pending = st_reg.out_pending;
      endcase
    end

    // receive side: slot refills only after the key is read
    if (access & ~pwrite & st_reg.rd_clear) begin
      st_next.rcvd = 1'b0;
    end
    if (arrive) begin
      st_next.rcvd   = 1'b1;
      st_next.rx_ctl = rx_header[7:0];
      st_next.perr   = ~odd_ones(rx_header, rx_payload);
      st_next.rx_word = rx_header[CB_DATA] ? rx_payload : '0;
      if (rx_header[CB_TYPE] == TYPE_MULTICAST) begin
        st_next.rx_key = rx_header[HDR_KEY_LSB +: WORD_W];
      end else begin
        st_next.rx_key = '0;
        st_next.rx_key[KD_DEST_LSB +: ID_W] = rx_header[HDR_SRC_LSB +: ID_W];
        st_next.rx_key[KD_SEQ_LSB +: 2]     = rx_header[CB_SEQ_LSB +: 2];
      end
    end
    st_next.rx_ready = ~st_next.rcvd;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.src_id   <= SRC_ID_RESET;
      st_reg.rx_ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata     = st_reg.prdata;
  assign pready     = st_reg.pready;
  assign pslverr    = st_reg.pslverr;
  assign tx_valid   = st_reg.tx_valid;
  assign tx_header  = st_reg.tx_header;
  assign tx_payload = st_reg.tx_payload;
  assign rx_ready   = st_reg.rx_ready;

endmodule // spc_comm_ctrl

// *** spc_asserts.sv ***
// spc_asserts: port-level checks of the packet controller
// assumes: bound onto spc_comm_ctrl, one clock pclk
`timescale 1ns/1ps
module spc_asserts
  import spc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  time_phase,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [39:0] tx_header,
  input wire logic [31:0] tx_payload,
  input wire logic        rx_valid,
  input wire logic        rx_ready
);
  // ==========================================
  // apb and network properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable && pready; endsequence
  sequence s_kd; s_acc ##0 pwrite && paddr == OFS_OUTGOING_KEY_DEST && !pslverr; endsequence
  property p_ack; psel && !penable |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("no ready after setup");
  property p_go; s_kd |=> $rose(tx_valid); endproperty
  a_go: assert property (p_go) else $error("write did not launch");
  property p_one; $rose(tx_valid) |-> $past(pwrite && paddr == OFS_OUTGOING_KEY_DEST); endproperty
  a_one: assert property (p_one) else $error("launch without write");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_header); endproperty
  a_hold: assert property (p_hold) else $error("send not held");
  property p_par; tx_valid |-> ^{tx_header, tx_header[CB_DATA] ? tx_payload : 32'h0}; endproperty
  a_par: assert property (p_par) else $error("even parity sent");
  property p_nod; tx_valid && !tx_header[CB_DATA] |-> tx_payload == 32'h0; endproperty
  a_nod: assert property (p_nod) else $error("payload without flag");
  property p_stamp; $rose(tx_valid) |-> tx_header[3:2] == $past(time_phase); endproperty
  a_stamp: assert property (p_stamp) else $error("wrong stamp");
  property p_emg; tx_valid && tx_header[CB_TYPE] == TYPE_MULTICAST |-> tx_header[5:4] == EMERG_NORMAL; endproperty
  a_emg: assert property (p_emg) else $error("multicast not normal");
  property p_rx; rx_valid && rx_ready |=> !rx_ready; endproperty
  a_rx: assert property (p_rx) else $error("slot not closed");
  property p_rsv; s_acc ##0 paddr == OFS_UNUSED_SLOT |-> pslverr && prdata == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved slot answered");
endmodule // spc_asserts
bind spc_comm_ctrl spc_asserts chk_u (.*);

// *** spc_net_model.sv ***
// spc_net_model: network side, sink for sends, source for arrivals
// assumes: test drives stall and calls send after a rising edge
`timescale 1ns/1ps
module spc_net_model (
  input  wire logic        pclk,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [39:0] tx_header,
  input  wire logic [31:0] tx_payload,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic      [39:0] rx_header,
  output logic      [31:0] rx_payload
);
  // ==========================================
  // send sink, may stall
  logic        stall = 0;
  logic [39:0] got_h;
  logic [31:0] got_p;
  int          got_n = 0;
  initial tx_ready = 0;
  initial rx_valid = 0;
  always @(posedge pclk) begin
    tx_ready <= !stall;
    if (tx_valid && tx_ready) begin
      got_h <= tx_header;
      got_p <= tx_payload;
      got_n <= got_n + 1;
    end
  end
  // ==========================================
  // arrival source; released lines show the inverse
  task automatic send(input logic [39:0] h, input logic [31:0] p);
    rx_valid <= 1;
    rx_header <= h;
    rx_payload <= p;
    do @(posedge pclk); while (!rx_ready);
    rx_valid <= 0;
    rx_header <= ~h;
    rx_payload <= ~p;
  endtask
endmodule // spc_net_model

// *** spc_comm_ctrl_test.sv ***
// spc_comm_ctrl_test: apb scenarios against the packet controller
// assumes: spc_net_model on the network, checker bound in
`timescale 1ns/1ps
module spc_comm_ctrl_test;
  import spc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, tx_payload, rx_payload, rd;
  logic pready, pslverr, tx_valid, tx_ready, rx_valid, rx_ready;
  logic [1:0] time_phase = 0;
  logic [39:0] tx_header, rx_header, hb;
  int err_count = 0, check_count = 0, cyc = 0, sent = 0;
  spc_comm_ctrl dut_u (.*);
  spc_net_model net_u (.*);
  initial forever #25 pclk = ~pclk;
  // timeout: whole run is about a hundred cycles
  always @(posedge pclk) if (++cyc > 5000) begin
    err_count++;
    end_of_test();
  end
  // ==========================================
  // shared tasks
  // wide enough for payload and header together
  task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // idle edge first so release and next setup never share a step
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e, input logic [31:0] x);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (!pready);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    cmp({er, rd}, {e, x});
  endtask
  function automatic logic [39:0] hdr(input logic [31:0] hi, input logic [6:0] c, input logic [31:0] p);
    return {hi, c, ~^{hi, c, c[5] ? p : 32'h0}};
  endfunction
  task automatic pkt(input logic [39:0] h, input logic [31:0] p);
    sent++;
    for (int k = 0; k < 30 && net_u.got_n != sent; k++) @(posedge pclk);
    cmp({net_u.got_p, net_u.got_h}, {p, h});
    // router side: a fresh launch must never look two phases old
    cmp((net_u.got_h[CB_STAMP_LSB +: 2] ^ time_phase) == 2'b11, 0);
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    acc(0, OFS_STATUS_CONFIG, 0, 0, 0);
    acc(0, OFS_UNUSED_SLOT, 0, 1, 0);
    acc(0, OFS_OUTGOING_PAYLOAD, 0, 1, 0);
    acc(0, OFS_OUTGOING_KEY_DEST, 0, 1, 0);
    acc(1, OFS_INCOMING_KEY_SOURCE, 1, 1, 0);
    acc(1, 8'h20, 1, 1, 0);
    acc(1, OFS_STATUS_CONFIG, 32'h0800_1234, 0, 0);
    acc(0, OFS_STATUS_CONFIG, 0, 0, 32'h0800_1234);
    $display("t_regs done");
  endtask
  // every seq code and phase; payload on the first two only
  task automatic t_p2p;
    for (int i = 0; i < 4; i++) begin
      time_phase <= 2'(i) ^ {1'b0, 1'(i >> 1)};
      if (i < 2) acc(1, OFS_OUTGOING_PAYLOAD, 32'hC0DE_0000 + i, 0, 0);
      acc(1, OFS_OUTGOING_KEY_DEST, {14'h0, 2'(i), 16'h00A5}, 0, 0);
      pkt(hdr({16'h00A5, 16'h1234}, {1'b1, i < 2, 2'(i), 2'(i) ^ {1'b0, 1'(i >> 1)}, 1'b1},
        32'hC0DE_0000 + i), i < 2 ? 32'hC0DE_0000 + i : 0);
    end
    $display("t_p2p done");
  endtask
  task automatic t_mc;
    time_phase <= 2'h0;
    acc(1, OFS_STATUS_CONFIG, 32'h0A00_0000, 0, 0);
    acc(1, OFS_OUTGOING_KEY_DEST, 32'hA5C3_0F1E, 0, 0);
    pkt(hdr(32'hA5C3_0F1E, {6'h0, 1'b1}, 0), 0);
    net_u.stall <= 1;
    acc(1, OFS_OUTGOING_KEY_DEST, 32'h0000_0001, 0, 0);
    acc(1, OFS_OUTGOING_KEY_DEST, 32'h0000_0002, 1, 0);
    acc(0, OFS_STATUS_CONFIG, 0, 0, 32'h0E00_0000);
    net_u.stall <= 0;
    pkt(hdr(32'h0000_0001, {6'h0, 1'b1}, 0), 0);
    $display("t_mc done");
  endtask
  // second arrival, with bad parity, waits for the key read
  task automatic t_rx;
    // interrupt enable on, so the status bit follows received
    acc(1, OFS_STATUS_CONFIG, 32'h4A00_0000, 0, 0);
    hb = hdr({16'h0005, 16'hBEEF}, 7'b1101001, 32'h1357_9BDF);
    net_u.send(hb, 32'h1357_9BDF);
    acc(0, OFS_STATUS_CONFIG, 0, 0, 32'hEA00_0000 | {8'h0, hb[7:0], 16'h0});
    hb = hdr(32'h7777_0001, 7'b0010010, 0) ^ 40'h1;
    fork
      net_u.send(hb, 0);
      begin
        acc(0, OFS_INCOMING_PAYLOAD, 0, 0, 32'h1357_9BDF);
        acc(0, OFS_INCOMING_KEY_SOURCE, 0, 0, 32'h0001_BEEF);
      end
    join
    acc(0, OFS_STATUS_CONFIG, 0, 0, 32'hFA00_0000 | {8'h0, hb[7:0], 16'h0});
    acc(0, OFS_INCOMING_KEY_SOURCE, 0, 0, 32'h7777_0001);
    acc(0, OFS_INCOMING_PAYLOAD, 0, 0, 0);
    $display("t_rx done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_p2p();
    t_mc();
    t_rx();
    end_of_test();
  end
endmodule // spc_comm_ctrl_test
